// *** design/adc_acquire_convert_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.svh"

// Notes on behaviour
// - Zero acquisition: convert at once on start
// - Nonzero acquisition: sample, then auto convert
// - End: clear start, set done, resume sampling
// - No acquisition/conversion phase status shown
// - Conversion lasts at least twelve bit periods
// - Clock select maps divider ratios, x11 RC
// - RC bit period typically four microseconds
// - RC clock needed for sleep operation
// - RC with zero acquisition: one instruction cycle (four clock) holdoff
// - Clearing start aborts, result unchanged
// - Two bit periods disconnected, then sample
// - Analog pins read zero on port
// - Acquisition select maps to bit periods
// - Justify bit places ten-bit result
// - Trigger sets start only when on
// - Reset switches off, aborts conversion
module adc_acquire_convert_sequencer
  import adc_seq_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  // Register port.
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Compare unit two special event trigger.
  input wire logic TRIGGER_I,
  // Successive approximation array.
  input wire logic [9:0] SAR_RESULT_I,
  output logic SAMPLE_O,
  output logic CONVERT_O,
  output logic BIT_STROBE_O,
  // Port pins and flags.
  input wire logic [7:0] PIN_I,
  output logic CONV_DONE_IRQ_FLAG_O
);

  // ************************************************************
  // Registers and synchronisers
  // ************************************************************

  reg_req_t req;
  seq_state_t state;
  logic converter_on;
  logic start_flag;
  logic [2:0] conv_clock_select;
  logic [2:0] acq_period_select;
  logic result_justify;
  logic conv_done_irq_flag;
  logic [9:0] result_pair;
  logic [7:0] analog_mask;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic trig_meta;
  logic trig_sync;
  logic [4:0] tad_count;
  logic [2:0] holdoff_count;
  logic tick;
  logic bit_run;
  logic wr_ctrl;
  logic finish;
  logic [4:0] acq_target;
  analog_ctl_t ana;

  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign wr_ctrl = req.wr && req.addr == `ADDR_CONTROL;

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
    end else begin
      pin_meta <= PIN_I;
      pin_sync <= pin_meta;
      trig_meta <= TRIGGER_I;
      trig_sync <= trig_meta;
    end
  end

  // Acquisition select to bit period count.
  function automatic logic [4:0] acq_periods(input logic [2:0] sel);
    unique case (sel)
      3'b000: acq_periods = 5'd0;
      3'b001: acq_periods = 5'd2;
      3'b010: acq_periods = 5'd4;
      3'b011: acq_periods = 5'd6;
      3'b100: acq_periods = 5'd8;
      3'b101: acq_periods = 5'd12;
      3'b110: acq_periods = 5'd16;
      3'b111: acq_periods = 5'd20;
    endcase
  endfunction

  assign acq_target = acq_periods(acq_period_select);

  // ************************************************************
  // Configuration registers
  // ************************************************************

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      converter_on <= 1'b0;
      conv_clock_select <= 3'b000;
      acq_period_select <= 3'b000;
      result_justify <= 1'b0;
      analog_mask <= `ANALOG_MASK_RESET;
    end else if (req.wr) begin
      if (req.addr == `ADDR_CONTROL) begin
        converter_on <= req.wdata[`CTRL_ON_BIT];
        conv_clock_select <= req.wdata[`CTRL_CLKSEL_LSB +: 3];
      end
      if (req.addr == `ADDR_CONFIG) begin
        acq_period_select <= req.wdata[`CFG_ACQ_LSB +: 3];
        result_justify <= req.wdata[`CFG_JUSTIFY_BIT];
      end
      if (req.addr == `ADDR_ANALOG_MASK) begin
        analog_mask <= req.wdata;
      end
    end
  end

  // ************************************************************
  // Start flag and done flag
  // ************************************************************

  assign finish = state == ST_CONVERT && tick && tad_count == 5'(`CONV_BIT_PERIODS - 1);

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_flag <= 1'b0;
    end else if (trig_sync && converter_on) begin
      start_flag <= 1'b1;
    end else if (wr_ctrl) begin
      start_flag <= req.wdata[`CTRL_START_BIT] && req.wdata[`CTRL_ON_BIT];
    end else if (finish || !converter_on) begin
      start_flag <= 1'b0;
    end
  end

  // The done flag is set by hardware and wins over a software clear.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      conv_done_irq_flag <= 1'b0;
    end else if (finish) begin
      conv_done_irq_flag <= 1'b1;
    end else if (req.wr && req.addr == `ADDR_STATUS && !req.wdata[`STAT_DONE_BIT]) begin
      conv_done_irq_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************

  // An abort stops the bit clock for one cycle, so no stray tick can finish the
  // conversion and the recovery that follows lasts two whole bit periods.
  assign bit_run = state != ST_SAMPLE && state != ST_HOLDOFF
                   && !(state == ST_CONVERT && !start_flag);

  adc_bit_clock u_bit_clock (
    .clk_i(REF_CLK_I),
    .resetn_i(RESETN_I),
    .run_i(bit_run),
    .sel_i(conv_clock_select),
    .tick_o(tick)
  );

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= ST_SAMPLE;
      tad_count <= 5'd0;
      holdoff_count <= 3'd0;
    end else if (!converter_on) begin
      state <= ST_SAMPLE;
      tad_count <= 5'd0;
    end else begin
      unique case (state)
        ST_SAMPLE: begin
          tad_count <= 5'd0;
          holdoff_count <= 3'd0;
          if (start_flag) begin
            if (acq_target != 5'd0) begin
              state <= ST_ACQUIRE;
            end else if (conv_clock_select[1:0] == 2'b11) begin
              state <= ST_HOLDOFF;
            end else begin
              state <= ST_CONVERT;
            end
          end
        end
        ST_HOLDOFF: begin
          holdoff_count <= holdoff_count + 3'd1;
          if (!start_flag) begin
            state <= ST_SAMPLE;
          end else if (holdoff_count == 3'(`INSTR_CYCLES - 1)) begin
            state <= ST_CONVERT;
          end
        end
        ST_ACQUIRE: begin
          if (!start_flag) begin
            state <= ST_SAMPLE;
          end else if (tick) begin
            if (tad_count == acq_target - 5'd1) begin
              tad_count <= 5'd0;
              state <= ST_CONVERT;
            end else begin
              tad_count <= tad_count + 5'd1;
            end
          end
        end
        ST_CONVERT: begin
          if (!start_flag) begin
            tad_count <= 5'd0;
            state <= ST_RECOVER;
          end else if (tick) begin
            if (finish) begin
              tad_count <= 5'd0;
              state <= ST_RECOVER;
            end else begin
              tad_count <= tad_count + 5'd1;
            end
          end
        end
        ST_RECOVER: begin
          if (tick) begin
            if (tad_count == 5'(`RECOVER_BIT_PERIODS - 1)) begin
              tad_count <= 5'd0;
              state <= ST_SAMPLE;
            end else begin
              tad_count <= tad_count + 5'd1;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Result pair
  // ************************************************************

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      result_pair <= 10'h000;
    end else if (finish) begin
      result_pair <= SAR_RESULT_I;
    end else if (req.wr && req.addr == `ADDR_RESULT_HIGH) begin
      result_pair <= result_justify ? {req.wdata[1:0], result_pair[7:0]}
                                    : {req.wdata, result_pair[1:0]};
    end else if (req.wr && req.addr == `ADDR_RESULT_LOW) begin
      result_pair <= result_justify ? {result_pair[9:8], req.wdata}
                                    : {result_pair[9:2], req.wdata[7:6]};
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************

  // The status word holds only the done flag; no phase is exposed.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `ADDR_CONTROL: RDATA_O <= {3'b000, conv_clock_select, start_flag, converter_on};
        `ADDR_CONFIG: RDATA_O <= {4'h0, result_justify, acq_period_select};
        `ADDR_RESULT_HIGH: RDATA_O <= result_justify ? {6'h00, result_pair[9:8]}
                                                     : result_pair[9:2];
        `ADDR_RESULT_LOW: RDATA_O <= result_justify ? result_pair[7:0]
                                                    : {result_pair[1:0], 6'h00};
        `ADDR_STATUS: RDATA_O <= {7'h00, conv_done_irq_flag};
        `ADDR_PORT_PINS: RDATA_O <= pin_sync & ~analog_mask;
        `ADDR_ANALOG_MASK: RDATA_O <= analog_mask;
        default: RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= 8'h00;
    end
  end

  // ************************************************************
  // Analog controls
  // ************************************************************

  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ana <= '0;
    end else begin
      ana.sample <= converter_on && (state == ST_SAMPLE || state == ST_ACQUIRE
                                     || state == ST_HOLDOFF);
      ana.convert <= state == ST_CONVERT && start_flag;
      ana.bit_strobe <= state == ST_CONVERT && tick;
    end
  end

  assign SAMPLE_O = ana.sample;
  assign CONVERT_O = ana.convert;
  assign BIT_STROBE_O = ana.bit_strobe;
  assign CONV_DONE_IRQ_FLAG_O = conv_done_irq_flag;

endmodule
`default_nettype wire

// *** design/adc_seq_defines.svh ***
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Register offsets (byte addresses on the plain register port).
`define ADDR_CONTROL 8'h00
`define ADDR_CONFIG 8'h04
`define ADDR_RESULT_HIGH 8'h08
`define ADDR_RESULT_LOW 8'h0c
`define ADDR_STATUS 8'h10
`define ADDR_PORT_PINS 8'h14
`define ADDR_ANALOG_MASK 8'h18

// Control register fields.
`define CTRL_ON_BIT 0
`define CTRL_START_BIT 1
`define CTRL_CLKSEL_LSB 2
`define CTRL_RESET 8'h00

// Configuration register fields.
`define CFG_ACQ_LSB 0
`define CFG_JUSTIFY_BIT 3
`define CFG_RESET 8'h00
`define ANALOG_MASK_RESET 8'hff

// Status register fields.
`define STAT_DONE_BIT 0

// Timing.
`define CLK_PERIOD_NS 10
`define RC_PERIOD_NS 4000
`define RC_CYCLES (`RC_PERIOD_NS / `CLK_PERIOD_NS)
`define INSTR_CYCLE_NS 40
`define INSTR_CYCLES ((`INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_BIT_PERIODS 12
`define RECOVER_BIT_PERIODS 2

`endif

// *** design/adc_seq_pkg.sv ***
package adc_seq_pkg;

  typedef enum logic [4:0] {
    ST_SAMPLE = 5'b00001,
    ST_HOLDOFF = 5'b00010,
    ST_ACQUIRE = 5'b00100,
    ST_CONVERT = 5'b01000,
    ST_RECOVER = 5'b10000
  } seq_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic sample;
    logic convert;
    logic bit_strobe;
  } analog_ctl_t;

endpackage

// *** design/adc_bit_clock.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.svh"

module adc_bit_clock
  import adc_seq_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control.
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  // Bit period strobe.
  output logic tick_o
);

  logic [11:0] count;
  logic [11:0] limit;

  // Divide ratio from the three select bits; x11 picks the RC period.
  function automatic logic [11:0] period_of(input logic [2:0] sel);
    unique case (sel)
      3'b000: period_of = 12'h002;
      3'b100: period_of = 12'h004;
      3'b001: period_of = 12'h008;
      3'b101: period_of = 12'h010;
      3'b010: period_of = 12'h020;
      3'b110: period_of = 12'h040;
      default: period_of = 12'(`RC_CYCLES);
    endcase
  endfunction

  assign limit = period_of(sel_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= 12'h000;
    end else if (!run_i || count == limit - 12'h001) begin
      count <= 12'h000;
    end else begin
      count <= count + 12'h001;
    end
  end

  assign tick_o = run_i && (count == limit - 12'h001);

endmodule
`default_nettype wire

// *** dv/adc_sar_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_sar_model
  import adc_seq_pkg::*;
(
  // Array control and result.
  input wire logic clk_i,
  input wire logic convert_i,
  input wire logic [9:0] value_i,
  output logic [9:0] result_o
);
  // Outside a conversion the array output is meaningless, so it toggles.
  initial result_o = 10'h155;
  always @(posedge clk_i) result_o <= convert_i ? value_i : ~result_o;
endmodule
`default_nettype wire

// *** dv/adc_seq_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module adc_seq_asserts
  import adc_seq_pkg::*;
(
  // Watched ports.
  input wire logic REF_CLK_I,
  input wire logic RESETN_I,
  input wire logic SAMPLE_O,
  input wire logic CONVERT_O,
  input wire logic BIT_STROBE_O,
  input wire logic CONV_DONE_IRQ_FLAG_O
);
  logic conv_d;
  logic [7:0] n_strobe;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Counts bit strobes of the latest conversion.
  always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      conv_d <= 1'b0;
      n_strobe <= 8'h00;
    end else begin
      conv_d <= CONVERT_O;
      if (CONVERT_O && !conv_d) n_strobe <= {7'h00, BIT_STROBE_O};
      else if (CONVERT_O && BIT_STROBE_O) n_strobe <= n_strobe + 8'h01;
    end
  end
  property p_excl; !(SAMPLE_O && CONVERT_O); endproperty
  a_excl: assert property (p_excl) else $error("sample during convert");
  // The last strobe is counted at the edge where the flag first shows, so look one cycle on.
  property p_len; $rose(CONV_DONE_IRQ_FLAG_O) |=> n_strobe >= 8'h0c; endproperty
  a_len: assert property (p_len) else $error("conversion too short");
  property p_hold; $rose(CONVERT_O) |-> CONVERT_O[*8]; endproperty
  a_hold: assert property (p_hold) else $error("conversion cut short");
  property p_done; $fell(CONVERT_O) && n_strobe >= 8'h0c |-> ##[0:2] CONV_DONE_IRQ_FLAG_O; endproperty
  a_done: assert property (p_done) else $error("done flag missing");
  property p_recover; $fell(CONVERT_O) |-> !SAMPLE_O[*3]; endproperty
  a_recover: assert property (p_recover) else $error("no recovery gap");
  property p_strobe_conv; BIT_STROBE_O |-> CONVERT_O; endproperty
  a_strobe_conv: assert property (p_strobe_conv) else $error("stray strobe");
  property p_strobe_gap; BIT_STROBE_O |=> !BIT_STROBE_O; endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobes adjacent");
  property p_reset; $rose(RESETN_I) |-> !SAMPLE_O && !CONVERT_O && !CONV_DONE_IRQ_FLAG_O; endproperty
  a_reset: assert property (p_reset) else $error("busy after reset");
endmodule
bind adc_acquire_convert_sequencer adc_seq_asserts u_asserts (.REF_CLK_I(REF_CLK_I),
  .RESETN_I(RESETN_I), .SAMPLE_O(SAMPLE_O), .CONVERT_O(CONVERT_O),
  .BIT_STROBE_O(BIT_STROBE_O), .CONV_DONE_IRQ_FLAG_O(CONV_DONE_IRQ_FLAG_O));
`default_nettype wire

// *** dv/test_adc_acquire_convert_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defines.svh"
module test_adc_acquire_convert_sequencer
  import adc_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic trig = 1'b0;
  logic [7:0] pin = 8'h00;
  logic [9:0] value = 10'h000;
  wire [9:0] sar;
  wire [7:0] rdata;
  wire sample, conv, strobe, flag;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [7:0] expq[$];
  int ratio[8] = '{2, 8, 32, `RC_CYCLES, 4, 16, 64, `RC_CYCLES};
  int acq_tad[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  always #5 clk = ~clk;
  adc_acquire_convert_sequencer u_dut (.REF_CLK_I(clk), .RESETN_I(rstn), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIGGER_I(trig),
    .SAR_RESULT_I(sar), .SAMPLE_O(sample), .CONVERT_O(conv), .BIT_STROBE_O(strobe),
    .PIN_I(pin), .CONV_DONE_IRQ_FLAG_O(flag));
  adc_sar_model u_sar (.clk_i(clk), .convert_i(conv), .value_i(value), .result_o(sar));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ****
  // Read data are compared one cycle after each read strobe.
  // ****
  always @(posedge clk) begin
    if (rd_d) chk({8'h00, rdata}, {8'h00, expq.pop_front()});
    rd_d <= rd;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) expq.push_back(d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wait_sig(input bit s, input logic v, output int n);
    n = 0;
    while ((s ? sample : conv) !== v && n < 9000) begin
      @(negedge clk);
      n++;
    end
    // A wait that runs out counts as a mismatch.
    if (n >= 9000) chk(16'(s ? sample : conv), 16'(v));
  endtask
  task automatic convert(input logic [2:0] cs, input logic [2:0] acq, input logic just,
    output int lat);
    int r;
    int t;
    int ns;
    r = ratio[cs];
    t = 0;
    ns = 0;
    value <= 10'($urandom);
    bus(1'b1, `ADDR_CONFIG, {4'h0, just, acq});
    bus(1'b1, `ADDR_CONTROL, {3'h0, cs, 2'b01});
    repeat (4) @(posedge clk);
    bus(1'b1, `ADDR_CONTROL, {3'h0, cs, 2'b11});
    wait_sig(1'b0, 1'b1, lat);
    while (conv === 1'b1 && t < 9000) begin
      ns += int'(strobe === 1'b1);
      t++;
      @(negedge clk);
    end
    chk(16'(ns), 16'h000c);
    chk(16'((t + r / 2) / r), 16'h000c);
    wait_sig(1'b1, 1'b1, t);
    chk(16'((t + r / 2) / r), 16'h0002);
    chk(16'(flag), 16'h0001);
    bus(1'b0, `ADDR_CONTROL, {3'h0, cs, 2'b01});
    bus(1'b0, `ADDR_STATUS, 8'h01);
    bus(1'b0, `ADDR_RESULT_HIGH, just ? {6'h00, value[9:8]} : value[9:2]);
    bus(1'b0, `ADDR_RESULT_LOW, just ? value[7:0] : {value[1:0], 6'h00});
    bus(1'b1, `ADDR_STATUS, 8'h00);
  endtask
  task automatic pulse;
    @(posedge clk);
    trig <= 1'b1;
    repeat (3) @(posedge clk);
    trig <= 1'b0;
    repeat (20) @(posedge clk);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #800000;
    n_mismatch++;
    test_done;
  end
  initial begin
    int l;
    int l0;
    logic [7:0] e;
    void'($urandom(80839));
    pin <= 8'($urandom);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) bus(1'b0, 8'(i * 4), i == 6 ? 8'hff : 8'h00);
    bus(1'b1, `ADDR_ANALOG_MASK, 8'h0f);
    bus(1'b0, `ADDR_PORT_PINS, pin & 8'hf0);
    // Bit periods under 1.6 us are swept only because the array model needs no settling.
    for (int c = 0; c < 8; c++) begin
      convert(3'(c), 3'h0, 1'(c), l);
      if (c == 0) l0 = l;
      if (c[1:0] == 2'b11) chk(16'(l - l0), 16'(`INSTR_CYCLES));
    end
    for (int a = 1; a < 8; a++) begin
      convert(3'h0, 3'(a), 1'(a), l);
      chk(16'((l - l0) / 2), 16'(acq_tad[a]));
    end
    e = value[7:0];
    value <= ~value;
    bus(1'b1, `ADDR_CONFIG, 8'h0f);
    bus(1'b1, `ADDR_CONTROL, 8'h19);
    bus(1'b1, `ADDR_CONTROL, 8'h1b);
    bus(1'b0, `ADDR_CONTROL, 8'h1b);
    bus(1'b0, `ADDR_STATUS, 8'h00);
    wait_sig(1'b0, 1'b1, l);
    repeat (100) @(posedge clk);
    bus(1'b1, `ADDR_CONTROL, 8'h19);
    wait_sig(1'b1, 1'b1, l);
    chk(16'((l + ratio[6] / 2) / ratio[6]), 16'h0002);
    bus(1'b0, `ADDR_STATUS, 8'h00);
    bus(1'b0, `ADDR_RESULT_LOW, e);
    bus(1'b1, `ADDR_RESULT_HIGH, 8'hff);
    bus(1'b0, `ADDR_RESULT_HIGH, 8'h03);
    bus(1'b1, `ADDR_CONTROL, 8'h00);
    pulse;
    bus(1'b0, `ADDR_CONTROL, 8'h00);
    bus(1'b1, `ADDR_CONTROL, 8'h01);
    pulse;
    bus(1'b0, `ADDR_CONTROL, 8'h03);
    wait_sig(1'b0, 1'b1, l);
    wait_sig(1'b0, 1'b0, l);
    bus(1'b0, `ADDR_STATUS, 8'h01);
    bus(1'b1, `ADDR_CONTROL, 8'h03);
    wait_sig(1'b0, 1'b1, l);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, `ADDR_CONTROL, 8'h00);
    @(negedge clk);
    chk(16'(conv), 16'h0000);
    repeat (3) @(posedge clk);
    test_done;
  end
endmodule
`default_nettype wire
